/* design/srctl_pkg.sv */
// srctl_pkg: constants and types shared by the system reset control block.
// assumes a single 10 MHz core clock; the watchdog pulse count derives from that rate.
package srctl_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ         = 64'd10_000_000;
    localparam longint WDT_PULSE_MS   = 64'd200;
    // least time: round up to whole cycles
    localparam longint WDT_PULSE_CYC  = (WDT_PULSE_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam int     EXT_MIN_CYCLES = 256;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int   PULSE_CNT_W  = 21;
    localparam int   LOW_CNT_W    = 9;
    localparam int   PIN_OUT_W    = 8;
    localparam int   OD_PIN_W     = 4;
    localparam int   SYNC_STAGES  = 2;
    localparam logic PIN_IDLE_VAL = 1'b1;   // reset pin reads high when idle

    // ------------------------------------------------------------------
    // reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_EXT = 3'b010,
        ST_WDT = 3'b100
    } srctl_state_t;

endpackage

/* design/srctl_sync.sv */
// srctl_sync: multi-stage level synchroniser for an asynchronous pin.
// assumes the input may change at any time relative to core_clk.
`timescale 1ns/10ps

module srctl_sync
    import srctl_pkg::*;
#(
    parameter int   STAGES    = SYNC_STAGES,
    parameter logic RESET_VAL = PIN_IDLE_VAL
) (
    input  wire logic core_clk,   // core clock
    input  wire logic reset,      // synchronous reset, active high
    input  wire logic asyncIn,    // asynchronous level
    output logic      syncOut     // level on core_clk
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("srctl_sync needs at least two stages");
    end

    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    // first stage feeds only the second; nothing else taps it
    always_comb begin
        next_chain = {chain[STAGES-2:0], asyncIn};
        if (reset) begin
            next_chain = {STAGES{RESET_VAL}};
        end
    end

    always_ff @(posedge core_clk) begin
        chain <= next_chain;
    end

    assign syncOut = chain[STAGES-1];

endmodule

/* design/srctl_reset_control.sv */
// srctl_reset_control: system reset sequencer for the controller.
// assumes the reset pin is asynchronous and wdtExpire is a core_clk pulse.
//
// How it works
// - low reset pin holds all blocks reset
// - outputs tri-stated throughout the reset state
// - open-drain pins released throughout reset state
// - watchdog expiry drives reset out 200ms+
`timescale 1ns/10ps

module srctl_reset_control
    import srctl_pkg::*;
#(
    parameter int unsigned WDT_PULSE_CYCLES = int'(WDT_PULSE_CYC),
    parameter int          CNT_W            = PULSE_CNT_W,
    parameter int          OUT_W            = PIN_OUT_W,
    parameter int          OD_W             = OD_PIN_W
) (
    input  wire logic             core_clk,        // core clock, 10 MHz
    input  wire logic             reset,           // power-on reset, active high
    input  wire logic             sysResetInN,     // board reset pin, active low
    input  wire logic             wdtExpire,       // watchdog expired, one pulse
    input  wire logic [OUT_W-1:0] funcPinOe,       // output enables from blocks
    input  wire logic [OD_W-1:0]  funcOdPullLow,   // open-drain pull-low requests
    output logic [OUT_W-1:0]      pinOe,           // pad output enables
    output logic [OD_W-1:0]       odPinOe,         // open-drain pad enables
    output logic                  blockReset,      // reset to cpu and blocks
    output logic                  wdtResetOut,     // watchdog reset output
    output logic                  extResetShort    // reset pin pulse too short
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (WDT_PULSE_CYCLES < 1 || longint'(WDT_PULSE_CYCLES) >= (64'd1 << CNT_W))
    begin : g_bad_pulse
        $error("watchdog pulse count does not fit the counter");
    end
    if (OUT_W < 1 || OD_W < 1) begin : g_bad_width
        $error("pin groups need at least one pin");
    end

    // ------------------------------------------------------------------
    // reset pin synchroniser
    // ------------------------------------------------------------------
    logic pinSync;
    logic extLow;

    srctl_sync #(
        .STAGES    (SYNC_STAGES),
        .RESET_VAL (PIN_IDLE_VAL)
    ) u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  (sysResetInN),
        .syncOut  (pinSync)
    );

    assign extLow = ~pinSync;

    // ------------------------------------------------------------------
    // sequencer state and watchdog pulse
    // ------------------------------------------------------------------
    srctl_state_t       state;
    srctl_state_t       next_state;
    logic [CNT_W-1:0]   pulseCnt;
    logic [CNT_W-1:0]   next_pulseCnt;
    logic               next_blockReset;
    logic               next_wdtResetOut;
    logic               wdtStart;

    // a timer that is itself held in reset cannot legally expire
    assign wdtStart = wdtExpire && (state == ST_RUN) && !extLow && (pulseCnt == '0);

    always_comb begin
        next_state    = state;
        next_pulseCnt = pulseCnt;
        if (wdtStart) begin
            next_pulseCnt = CNT_W'(WDT_PULSE_CYCLES);
        end else if (pulseCnt != '0) begin
            // runs on through a pin reset so only the reset input can cut the pulse short
            next_pulseCnt = pulseCnt - CNT_W'(1);
        end
        case (state)
            ST_RUN: begin
                if (extLow) begin
                    next_state = ST_EXT;
                end else if (wdtStart) begin
                    next_state = ST_WDT;
                end
            end
            ST_EXT: begin
                if (!extLow && next_pulseCnt != '0) begin
                    // pin let go mid-pulse: blocks stay down until it ends
                    next_state = ST_WDT;
                end else if (!extLow) begin
                    next_state = ST_RUN;
                end
            end
            ST_WDT: begin
                if (extLow) begin
                    next_state = ST_EXT;
                end else if (next_pulseCnt == '0) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_EXT;
            end
        endcase
        if (reset) begin
            next_state    = ST_EXT;
            next_pulseCnt = '0;
        end
        // one flop drives every block, so all leave reset together
        next_blockReset  = reset || (next_state != ST_RUN);
        next_wdtResetOut = !reset && (next_pulseCnt != '0);
    end

    always_ff @(posedge core_clk) begin
        state       <= next_state;
        pulseCnt    <= next_pulseCnt;
        blockReset  <= next_blockReset;
        wdtResetOut <= next_wdtResetOut;
    end

    // ------------------------------------------------------------------
    // pad gating
    // ------------------------------------------------------------------
    always_comb begin
        pinOe   = funcPinOe & {OUT_W{~blockReset}};
        odPinOe = funcOdPullLow & {OD_W{~blockReset}};
    end

    // ------------------------------------------------------------------
    // reset pin width monitor
    // ------------------------------------------------------------------
    // flags a board that violates the minimum hold; reset still obeyed
    logic [LOW_CNT_W-1:0] lowCnt;
    logic [LOW_CNT_W-1:0] next_lowCnt;
    logic                 next_extResetShort;

    always_comb begin
        next_lowCnt        = '0;
        next_extResetShort = 1'b0;
        if (extLow) begin
            next_lowCnt = lowCnt;
            if (lowCnt < LOW_CNT_W'(EXT_MIN_CYCLES)) begin
                next_lowCnt = lowCnt + LOW_CNT_W'(1);
            end
        end else if (lowCnt != '0 && lowCnt < LOW_CNT_W'(EXT_MIN_CYCLES)) begin
            next_extResetShort = 1'b1;
        end
        if (reset) begin
            next_lowCnt        = '0;
            next_extResetShort = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        lowCnt        <= next_lowCnt;
        extResetShort <= next_extResetShort;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic [31:0] hiCnt;
    logic [31:0] next_hiCnt;

    always_comb begin
        next_hiCnt = '0;
        if (wdtResetOut && !reset) begin
            next_hiCnt = hiCnt + 32'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        hiCnt <= next_hiCnt;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    pin_holds_reset_a: assert property (extLow |=> blockReset)
        else $error("pin reset did not hold blocks in reset");

    pin_low_reaches_a: assert property (
        $fell(pinSync) |=> blockReset [*2])
        else $error("blocks not reset after pin went low");

    pads_tristate_a: assert property (blockReset |-> pinOe == '0)
        else $error("output pad driven during reset");

    pads_follow_a: assert property (!blockReset |-> pinOe == funcPinOe)
        else $error("output enables blocked outside reset");

    od_released_a: assert property (blockReset |-> odPinOe == '0)
        else $error("open-drain pad pulled low during reset");

    wdt_start_a: assert property (wdtStart |=> wdtResetOut && blockReset)
        else $error("watchdog expiry did not start reset output");

    wdt_width_a: assert property (
        $fell(wdtResetOut) && !$past(reset) |-> hiCnt >= WDT_PULSE_CYCLES)
        else $error("watchdog reset output shorter than minimum");

    wdt_holds_blocks_a: assert property (wdtResetOut |-> blockReset)
        else $error("blocks released during watchdog reset pulse");

    release_sync_a: assert property (
        $fell(blockReset) |-> !wdtResetOut && !$past(extLow))
        else $error("blocks released while a reset source active");

    cv_pin_reset: cover property ($rose(blockReset) ##[1:300] $fell(blockReset));
    cv_wdt_pulse: cover property (wdtStart ##1 wdtResetOut);
    cv_short_pin: cover property (extResetShort);
    cv_pin_in_wdt: cover property (state == ST_WDT ##1 state == ST_EXT);

endmodule

/* dv/srctl_board_model.sv */
// srctl_board_model: board reset circuit that pulls the reset pin low on request.
// assumes requests are sampled on the rising core_clk edge; pin has a pull-up.
`timescale 1ns/10ps

module srctl_board_model (
    input  wire logic       core_clk,     // core clock
    input  wire logic       pressReq,     // start a low period
    input  wire logic [9:0] lowLen,       // low period in cycles
    output logic            sysResetInN   // reset pin, pulled up when idle
);
    logic [9:0] lowCnt = 10'h000;
    logic       pinLow = 1'b0;

    // released pin goes back to the pull-up level
    assign sysResetInN = ~pinLow;

    // lengths below 256 only when a scenario asks for a short press
    always @(posedge core_clk) begin
        if (pressReq) begin
            lowCnt <= lowLen - 10'h001;
            pinLow <= 1'b1;
        end else if (lowCnt != 10'h000) begin
            lowCnt <= lowCnt - 10'h001;
        end else begin
            pinLow <= 1'b0;
        end
    end
endmodule

/* dv/testbench.sv */
// testbench: scenario tasks for the system reset control block.
// assumes the watchdog pulse is shortened to WDT_CYC cycles for simulation.
`timescale 1ns/10ps

module testbench
    import srctl_pkg::*;
;
    localparam int WDT_CYC = 20;

    logic       core_clk = 1'b0;
    logic       reset = 1'b1;
    logic       wdtExpire = 1'b0;
    logic [7:0] funcPinOe = 8'ha5;
    logic [3:0] funcOdPullLow = 4'h9;
    logic       pressReq = 1'b0;
    logic [9:0] lowLen = 10'h000;
    logic       sysResetInN;
    logic [7:0] pinOe;
    logic [3:0] odPinOe;
    logic       blockReset;
    logic       wdtResetOut;
    logic       extResetShort;
    int         miscompares = 0;
    int         checked = 0;

    srctl_reset_control #(.WDT_PULSE_CYCLES(WDT_CYC)) u_dut (
        .core_clk(core_clk), .reset(reset), .sysResetInN(sysResetInN),
        .wdtExpire(wdtExpire), .funcPinOe(funcPinOe), .funcOdPullLow(funcOdPullLow),
        .pinOe(pinOe), .odPinOe(odPinOe), .blockReset(blockReset),
        .wdtResetOut(wdtResetOut), .extResetShort(extResetShort));

    srctl_board_model u_board (
        .core_clk(core_clk), .pressReq(pressReq), .lowLen(lowLen),
        .sysResetInN(sysResetInN));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_held(input string what);
        chk({what, " blockReset"}, 8'h01, {7'h00, blockReset});
        chk({what, " pinOe"}, 8'h00, pinOe);
        chk({what, " odPinOe"}, 8'h00, {4'h0, odPinOe});
    endtask

    // waits out the pin, then the three-edge release and the short flag
    task automatic wait_release(input logic [7:0] expShort);
        int i;
        int shorts;
        shorts = 0;
        for (i = 0; i < 400 && sysResetInN !== 1'b1; i++) begin
            chk_held("pin low");
            @(negedge core_clk);
        end
        repeat (4) begin
            @(negedge core_clk);
            shorts += (extResetShort === 1'b1);
        end
        chk("released blockReset", 8'h00, {7'h00, blockReset});
        chk("released pinOe", funcPinOe, pinOe);
        chk("released odPinOe", {4'h0, funcOdPullLow}, {4'h0, odPinOe});
        chk("short flag count", expShort, shorts[7:0]);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_power_on;
        repeat (3) @(negedge core_clk);
        chk_held("in reset");
        chk("in reset wdtResetOut", 8'h00, {7'h00, wdtResetOut});
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("after reset blockReset", 8'h00, {7'h00, blockReset});
        chk("after reset pinOe", funcPinOe, pinOe);
    endtask

    task automatic t_pin(input logic [9:0] len, input logic [7:0] expShort);
        funcPinOe = ~funcPinOe;
        pressReq  = 1'b1;
        lowLen    = len;
        @(negedge core_clk);
        pressReq = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_held("pin press");
        wdtExpire = 1'b1;
        @(negedge core_clk);
        wdtExpire = 1'b0;
        chk("pin press wdtResetOut", 8'h00, {7'h00, wdtResetOut});
        wait_release(expShort);
    endtask

    // watchdog pulse, with a refused second expiry and optional pin press
    task automatic t_wdt(input logic pinDuring);
        int n;
        wdtExpire = 1'b1;
        @(negedge core_clk);
        wdtExpire = 1'b0;
        lowLen    = 10'd30;
        n = 0;
        while (wdtResetOut === 1'b1 && n < 100) begin
            n++;
            chk_held("watchdog pulse");
            wdtExpire = (n == 5);
            pressReq  = pinDuring && (n == 3);
            @(negedge core_clk);
        end
        chk("watchdog length", WDT_CYC[7:0], n[7:0]);
        chk("after pulse blockReset", {7'h00, pinDuring}, {7'h00, blockReset});
        wait_release({7'h00, pinDuring});
    endtask

    initial begin
        #(100 * 5000);
        miscompares++;
        end_sim();
    end

    initial begin
        t_power_on();
        t_pin(10'd256, 8'h00);
        t_pin(10'd255, 8'h01);
        t_wdt(1'b0);
        t_wdt(1'b1);
        end_sim();
    end
endmodule
